/* File: rcod_pkg.sv */
/*
  Constants for the reference clock output divider: register map,
  control field layout, reset values and bus answer codes.
  Assumes a 32-bit Avalon-MM slave port with word addressing.
*/
package rcod_pkg;
  localparam int          ADDR_W        = 2;
  localparam int          DATA_W        = 32;
  localparam int          BE_W          = 4;
  localparam int          CTRL_W        = 8;
  localparam int          DIV_W         = 3;
  localparam int          DUTY_W        = 2;
  localparam int          CNT_W         = 7;
  localparam int          DIVISOR_W     = 8;
  // register indices; byte address is four times the index
  localparam logic [1:0]  CTRL_IDX      = 2'h0;
  localparam logic [1:0]  STAT_IDX      = 2'h1;
  // control field positions
  localparam int          EN_BIT        = 7;
  localparam int          DUTY_LSB      = 3;
  localparam int          DIV_LSB       = 0;
  localparam logic [7:0]  CTRL_WMASK    = 8'h9F;
  localparam logic [7:0]  CTRL_RESET    = 8'h10;
  // status field positions
  localparam int          ST_RUN_BIT    = 0;
  localparam int          ST_FROZEN_BIT = 1;
  localparam int          ST_LEVEL_BIT  = 2;
  localparam int          ST_CHG_BIT    = 3;
  // divider and duty codes
  localparam logic [2:0]  DIV_BYPASS    = 3'h0;
  localparam logic [2:0]  DIV_BY2       = 3'h1;
  localparam logic [1:0]  DUTY_ZERO     = 2'h0;
  localparam logic [1:0]  DUTY_QUARTER  = 2'h1;
  localparam logic [1:0]  DUTY_HALF     = 2'h2;
  localparam logic [1:0]  DUTY_3QUARTER = 2'h3;
  // avalon response codes
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECODE   = 2'h3;
endpackage

/* File: rcod_wave_if.sv */
/*
  Bundle between the control core, the period counter and the duty shaper.
  Assumes all three sit on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface rcod_wave_if;
  logic                            run;
  logic                            hold;
  logic [rcod_pkg::DIV_W-1:0]      div_sel;
  logic [rcod_pkg::DUTY_W-1:0]     duty_sel;
  logic [rcod_pkg::CNT_W-1:0]      count;
  logic                            wave;

  modport ctrl  (output run, hold, div_sel, duty_sel, input count, wave);
  modport cnt   (input run, hold, div_sel, output count);
  modport shape (input run, hold, div_sel, duty_sel, count, output wave);
endinterface
`default_nettype wire

/* File: rcod_divider.sv */
/*
  Period counter: counts 0 .. divisor-1 on the system clock.
  Assumes run and hold come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rcod_divider (
  // clock and reset
  input  wire logic   ref_clk_in,
  input  wire logic   reset_in,
  // wave bundle
  rcod_wave_if.cnt    wave_if
);
  logic [rcod_pkg::CNT_W-1:0]  last_count;

  // power-of-two divide: terminal count is 2**sel - 1
  assign last_count = rcod_pkg::CNT_W'((rcod_pkg::DIVISOR_W'(1) << wave_if.div_sel)
                                       - rcod_pkg::DIVISOR_W'(1)); // [R7]

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      wave_if.count <= '0;
    else if (!wave_if.run)
      wave_if.count <= '0;                            // [R14]
    else if (!wave_if.hold)                           // [R11]
      wave_if.count <= (wave_if.count >= last_count) ? '0
                     : rcod_pkg::CNT_W'(wave_if.count + 1'b1);
  end
endmodule // rcod_divider
`default_nettype wire

/* File: rcod_shaper.sv */
/*
  Duty shaper: registered high/low phase from the period count.
  Assumes the count restarts at zero on each period.
*/
`timescale 1ns/1ps
`default_nettype none
module rcod_shaper (
  // clock and reset
  input  wire logic   ref_clk_in,
  input  wire logic   reset_in,
  // wave bundle
  rcod_wave_if.shape  wave_if
);
  logic [rcod_pkg::DIVISOR_W-1:0]  quarter;
  logic [rcod_pkg::DIVISOR_W-1:0]  high_len;
  logic                            next_wave;

  always_comb
  begin
    quarter  = (rcod_pkg::DIVISOR_W'(1) << wave_if.div_sel) >> 2;
    high_len = rcod_pkg::DIVISOR_W'(quarter * wave_if.duty_sel); // [R8]
    if (wave_if.duty_sel == rcod_pkg::DUTY_ZERO)
      next_wave = 1'b0;                                          // [R8]
    else if (wave_if.div_sel == rcod_pkg::DIV_BY2)
      // half-cycle duties are finished with the clock in the core
      next_wave = (wave_if.count == '0);
    else
      next_wave = ({1'b0, wave_if.count} < high_len);
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      wave_if.wave <= 1'b0;
    else if (!wave_if.run)
      wave_if.wave <= 1'b0;                                      // [R14]
    else if (!wave_if.hold)
      wave_if.wave <= next_wave;                                 // [R11]
  end
endmodule // rcod_shaper
`default_nettype wire

/* File: rcod_top.sv */
/*
  Reference clock output divider: control register behind an Avalon-MM
  slave, power-of-two divider with selectable duty, output to a pin and
  to on-chip consumers such as the data signal modulator.
  Assumes ref_clk_in is the system clock and sleep_in comes from the
  power controller on that same clock.
  // Behaviour
  // R1: output derived only from the system clock
  // R2: generated clock drives pin when enabled
  // R3: same clock offered to internal peripherals
  // R4: enabling starts cleanly, no runt pulse
  // R5: clearing enable stops output at once
  // R6: settings may change while running; glitches possible
  // R7: divider field selects power-of-two divide
  // R8: duty field selects 0/25/50/75 percent high
  // R9: undivided setting ignores duty, passes clock
  // R10: duty resets to 50 percent
  // R11: sleep freezes outputs at present level
  // R12: enable bit7, duty bits4-3, divider bits2-0
  // R13: bits 6-5 read zero, writes ignored
  // R14: disabled: counter cleared, output low
*/
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module rcod_top (
  // clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_in,
  // power state
  input  wire logic                          sleep_in,
  // avalon-mm slave
  input  wire logic [rcod_pkg::ADDR_W-1:0]   avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [rcod_pkg::DATA_W-1:0]   avs_writedata_in,
  input  wire logic [rcod_pkg::BE_W-1:0]     avs_byteenable_in,
  output logic      [rcod_pkg::DATA_W-1:0]   avs_readdata_out,
  output logic      [1:0]                    avs_response_out,
  output logic                               avs_waitrequest_out,
  // generated clock
  output logic                               refout_pin_out,
  output logic                               refout_periph_out
);
  // control register fields
  logic                              refout_enable;
  logic [rcod_pkg::DUTY_W-1:0]       refout_duty_select;
  logic [rcod_pkg::DIV_W-1:0]        refout_divider_select;
  logic [rcod_pkg::CTRL_W-1:0]       ref_clock_control;
  // bus handshake
  logic                              bus_req;
  logic                              bus_ack;
  logic                              bus_hit_ctrl;
  logic                              bus_hit_stat;
  logic                              bus_mapped;
  logic                              ctrl_wr;
  logic                              stat_wr;
  logic [rcod_pkg::CTRL_W-1:0]       wr_byte;
  logic [rcod_pkg::DATA_W-1:0]       next_readdata;
  // status
  logic                              cfg_changed;
  logic                              chg_set;
  logic                              chg_clr;
  logic [rcod_pkg::DATA_W-1:0]       status_word;
  // waveform assembly
  logic                              clk_gate;
  logic                              bypass_mode;
  logic                              half_mode;
  logic                              live_level;
  logic                              settled_level;
  logic                              freeze_level;
  logic                              half_lead;
  logic                              refout_level;

  rcod_wave_if wave_bus ();

  // register image: unimplemented bits 6-5 are constant zero
  assign ref_clock_control = {refout_enable,
                              2'h0,                                    // [R13]
                              refout_duty_select,
                              refout_divider_select};                  // [R12]

  // bus decode
  assign bus_req      = avs_read_in | avs_write_in;
  assign bus_hit_ctrl = (avs_address_in == rcod_pkg::CTRL_IDX);
  assign bus_hit_stat = (avs_address_in == rcod_pkg::STAT_IDX);
  assign bus_mapped   = bus_hit_ctrl | bus_hit_stat;

  // one wait cycle on every access; waitrequest is high while idle,
  // which also covers the reset period
  assign avs_waitrequest_out = ~bus_ack;

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      bus_ack <= 1'b0;
    else
      bus_ack <= bus_req & ~bus_ack;
  end

  // a write takes effect at the edge where waitrequest is seen low
  assign ctrl_wr = avs_write_in & bus_ack & bus_hit_ctrl & avs_byteenable_in[0];
  assign stat_wr = avs_write_in & bus_ack & bus_hit_stat & avs_byteenable_in[0];
  assign wr_byte = avs_writedata_in[rcod_pkg::CTRL_W-1:0] & rcod_pkg::CTRL_WMASK; // [R13]

  // control register; fields are live immediately, even while running
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      refout_enable         <= rcod_pkg::CTRL_RESET[rcod_pkg::EN_BIT];
      refout_duty_select    <= rcod_pkg::CTRL_RESET[rcod_pkg::DUTY_LSB +: rcod_pkg::DUTY_W]; // [R10]
      refout_divider_select <= rcod_pkg::CTRL_RESET[rcod_pkg::DIV_LSB +: rcod_pkg::DIV_W];
    end
    else if (ctrl_wr)
    begin
      refout_enable         <= wr_byte[rcod_pkg::EN_BIT];                         // [R12]
      refout_duty_select    <= wr_byte[rcod_pkg::DUTY_LSB +: rcod_pkg::DUTY_W];   // [R6]
      refout_divider_select <= wr_byte[rcod_pkg::DIV_LSB +: rcod_pkg::DIV_W];     // [R6]
    end
  end

  // sticky warning: divider or duty rewritten while the output runs,
  // the case where the output may glitch
  assign chg_set = ctrl_wr & refout_enable &
                   ((wr_byte[rcod_pkg::DUTY_LSB +: rcod_pkg::DUTY_W] != refout_duty_select) |
                    (wr_byte[rcod_pkg::DIV_LSB +: rcod_pkg::DIV_W] != refout_divider_select)); // [R6]
  assign chg_clr = stat_wr & avs_writedata_in[rcod_pkg::ST_CHG_BIT];

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      cfg_changed <= 1'b0;
    else
      cfg_changed <= chg_set | (cfg_changed & ~chg_clr);
  end

  // status word
  always_comb
  begin
    status_word                            = '0;
    status_word[rcod_pkg::ST_RUN_BIT]      = refout_enable & ~sleep_in;
    status_word[rcod_pkg::ST_FROZEN_BIT]   = refout_enable & sleep_in;
    // in sleep the pin shows the frozen level, so report that one
    status_word[rcod_pkg::ST_LEVEL_BIT]    = sleep_in ? freeze_level : settled_level;
    status_word[rcod_pkg::ST_CHG_BIT]      = cfg_changed;
  end

  // read data is loaded on the first edge of an access and stands
  // through the edge where waitrequest is low
  always_comb
  begin
    next_readdata = '0;
    if (bus_hit_ctrl)
      next_readdata = rcod_pkg::DATA_W'(ref_clock_control);                // [R13]
    else if (bus_hit_stat)
      next_readdata = status_word;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      avs_readdata_out <= '0;
      avs_response_out <= rcod_pkg::RESP_OKAY;
    end
    else if (bus_req & ~bus_ack)
    begin
      avs_readdata_out <= avs_read_in ? next_readdata : '0;
      avs_response_out <= bus_mapped ? rcod_pkg::RESP_OKAY : rcod_pkg::RESP_DECODE;
    end
  end

  // drive the counter and the shaper
  assign wave_bus.run      = refout_enable;                                 // [R14]
  assign wave_bus.hold     = sleep_in;                                      // [R11]
  assign wave_bus.div_sel  = refout_divider_select;
  assign wave_bus.duty_sel = refout_duty_select;

  rcod_divider u_divider (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .wave_if    (wave_bus.cnt)
  );

  rcod_shaper u_shaper (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .wave_if    (wave_bus.shape)
  );

  // clock gate enable changes only while the clock is low, so the
  // first clock pulse after enabling is always whole
  always_ff @(negedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      clk_gate <= 1'b0;
    else
      clk_gate <= refout_enable & ~sleep_in;                                // [R4]
  end

  // count-zero flag taken on the falling edge, so it is steady across the
  // rising edge that opens the quarter pulse; the registered wave moves at
  // that same edge and would cut a runt pulse every period
  always_ff @(negedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      half_lead <= 1'b0;
    else
      half_lead <= (wave_bus.count == '0);                                  // [R8]
  end

  assign bypass_mode = (refout_divider_select == rcod_pkg::DIV_BYPASS);
  assign half_mode   = (refout_divider_select == rcod_pkg::DIV_BY2);

  // the only timing source is the system clock, so a clock switch
  // upstream shows straight through on the output
  always_comb
  begin
    live_level = wave_bus.wave;                                             // [R1]
    if (bypass_mode)
      live_level = ref_clk_in & clk_gate;                                   // [R9]
    else if (half_mode)
    begin
      // divide by 2 at 25 and 75 percent needs half-cycle resolution: mix in the clock itself
      unique case (refout_duty_select)
        rcod_pkg::DUTY_QUARTER:  live_level = half_lead & ref_clk_in & clk_gate;       // [R8]
        rcod_pkg::DUTY_3QUARTER: live_level = wave_bus.wave | (ref_clk_in & clk_gate); // [R8]
        rcod_pkg::DUTY_HALF:     live_level = wave_bus.wave;
        rcod_pkg::DUTY_ZERO:     live_level = 1'b0;                                    // [R8]
      endcase
    end
  end

  // level the output rests at during the clock-low half of a cycle;
  // this is the level held when sleep stops the waveform
  assign settled_level = refout_enable & wave_bus.wave & ~bypass_mode &
                         ~(half_mode & (refout_duty_select == rcod_pkg::DUTY_QUARTER));

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      freeze_level <= 1'b0;
    else if (!sleep_in)
      freeze_level <= settled_level;                                        // [R11]
  end

  // enable gates the final level directly: clearing it cuts the output
  // in the same cycle without finishing the period
  assign refout_level = refout_enable &                                     // [R5]
                        (sleep_in ? freeze_level : live_level);             // [R11]

  assign refout_pin_out    = refout_level;                                  // [R2]
  assign refout_periph_out = refout_level;                                  // [R3]

endmodule // rcod_top
`default_nettype wire

/* File: rcod_pin_model.sv */
/*
  Far-side model: the pin and an on-chip consumer of the generated clock.
  Assumes both outputs of rcod_top are wired straight to it.
*/
`timescale 1ns/1ps
`default_nettype none
module rcod_pin_model (
  // clock
  input  wire logic ref_clk_in,
  // generated clock as seen by pin and consumer
  input  wire logic refout_pin_in,
  input  wire logic refout_periph_in,
  // observations
  output var  int   rise_count_out,
  output var  int   fault_count_out
);
  initial rise_count_out = 0;
  initial fault_count_out = 0;
  // a pin load sees every rising edge, also those of the gated base clock
  always @(posedge refout_pin_in) rise_count_out = rise_count_out + 1;
  // the consumer must see the pin waveform; settled mid-cycle
  // compare a little after the edge, once both copies have settled
  always @(negedge ref_clk_in)
    #2 if (refout_periph_in !== refout_pin_in) fault_count_out = fault_count_out + 1;
endmodule // rcod_pin_model
`default_nettype wire

/* File: rcod_checker.sv */
/*
  Bus and output properties of rcod_top.
  Assumes it is bound to rcod_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module rcod_checker (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // inputs of the block
  input  wire logic        sleep_in,
  input  wire logic [1:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  // outputs of the block
  input  wire logic [31:0] avs_readdata_out,
  input  wire logic [1:0]  avs_response_out,
  input  wire logic        avs_waitrequest_out,
  input  wire logic        refout_pin_out,
  input  wire logic        refout_periph_out
);
  logic [7:0] shadow;
  logic       done;
  assign done = !avs_waitrequest_out && (avs_read_in || avs_write_in);
  // shadow copy of the control register, rebuilt from completed writes
  always_ff @(posedge ref_clk_in or posedge reset_in)
    if (reset_in) shadow <= rcod_pkg::CTRL_RESET;
    else if (done && avs_write_in && avs_address_in == 2'h0 && avs_byteenable_in[0])
      shadow <= avs_writedata_in[7:0] & rcod_pkg::CTRL_WMASK;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
  property p_wait_back;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_back: assert property (p_wait_back) else $error("answer longer than one cycle");
  property p_idle;
    !(avs_read_in || avs_write_in) |-> avs_waitrequest_out;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_decode;
    done && avs_address_in[1] |-> avs_response_out == 2'h3 && avs_readdata_out == 32'h0;
  endproperty
  a_decode: assert property (p_decode) else $error("unmapped access not refused");
  property p_okay;
    done && !avs_address_in[1] |-> avs_response_out == 2'h0;
  endproperty
  a_okay: assert property (p_okay) else $error("mapped access refused");
  property p_readback;
    done && avs_read_in && avs_address_in == 2'h0 |-> avs_readdata_out == {24'h0, shadow};
  endproperty
  a_readback: assert property (p_readback) else $error("control readback wrong");
  property p_periph;
    refout_periph_out == refout_pin_out;
  endproperty
  a_periph: assert property (p_periph) else $error("consumer copy differs from pin");
  property p_off_low;
    !shadow[7] |-> !refout_pin_out;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output not low while disabled");
  property p_sleep_hold;
    sleep_in && $past(sleep_in) && shadow[7] && $past(shadow[7]) |-> $stable(refout_pin_out);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("output moved in sleep");
endmodule // rcod_checker
bind rcod_top rcod_checker chk_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .sleep_in(sleep_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_response_out(avs_response_out), .avs_waitrequest_out(avs_waitrequest_out),
  .refout_pin_out(refout_pin_out), .refout_periph_out(refout_periph_out));
`default_nettype wire

/* File: tb_reference_clock_output_divider.sv */
/*
  Self-checking bench: Avalon master, waveform model, pin model.
  Assumes rcod_top with one wait per access and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin errors++; $display("CHECK FAILED %0t %s", $time, msg); end end
module tb_reference_clock_output_divider;
  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        sleep_in = 1'b0;
  logic [1:0]  avs_address_in = 2'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'h0;
  logic [31:0] avs_readdata_out;
  logic [1:0]  avs_response_out;
  logic        avs_waitrequest_out;
  logic        refout_pin_out;
  logic        refout_periph_out;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          rises, faults, r0, n, hi, model_ctrl;
  logic [7:0]  lfsr = 8'h61;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic        lv;
  always #12.5 ref_clk_in = ~ref_clk_in;
  rcod_top dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .sleep_in(sleep_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_response_out(avs_response_out), .avs_waitrequest_out(avs_waitrequest_out),
    .refout_pin_out(refout_pin_out), .refout_periph_out(refout_periph_out));
  rcod_pin_model pin_u (.ref_clk_in(ref_clk_in), .refout_pin_in(refout_pin_out),
    .refout_periph_in(refout_periph_out), .rise_count_out(rises), .fault_count_out(faults));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task final_report;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one access; upper write data is random junk the block must ignore
  task bus(input logic wr, input logic [1:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge ref_clk_in);
    lfsr = lfsr_next(lfsr);
    avs_address_in <= a;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_writedata_in <= {lfsr, ~lfsr, lfsr, d};
    avs_byteenable_in <= be;
    // waitrequest is sampled at rising edges only; the bench timeout ends a hang
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0)
      @(posedge ref_clk_in);
    rd = avs_readdata_out;
    rsp = avs_response_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (wr && a == 2'h0 && be[0]) model_ctrl = d & 8'h9F;
  endtask
  task wcfg(input logic en, input logic [1:0] dt, input logic [2:0] dv);
    bus(1'b1, 2'h0, {en, lfsr[1:0], dt, dv}, 4'h1);
  endtask
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("CHECK FAILED %0t timeout", $time);
      final_report();
    end
  end
  initial
  begin
    model_ctrl = 8'h10;
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    bus(1'b0, 2'h0, 8'h0, 4'hF); `CHK(rd[7:0], model_ctrl[7:0], "ctrl reset")
    bus(1'b0, 2'h2, 8'h0, 4'hF); `CHK(rsp, 2'h3, "unmapped read")
    bus(1'b1, 2'h0, 8'hFF, 4'hE);
    bus(1'b0, 2'h0, 8'h0, 4'hF); `CHK(rd, model_ctrl, "lane ignored")
    bus(1'b1, 2'h0, 8'hE5, 4'h1);
    bus(1'b0, 2'h0, 8'h0, 4'hF); `CHK(rd, model_ctrl, "bits 6-5")
    for (int dv = 1; dv < 8; dv++)
      for (int dt = 0; dt < 4; dt++)
        begin
          n = 1 << dv;
          hi = n * dt / 4;
          wcfg(1'b0, dt[1:0], dv[2:0]);
          wcfg(1'b1, dt[1:0], dv[2:0]);
          r0 = rises;
          for (int i = 0; i < 2 * n; i++)
          begin
            @(negedge ref_clk_in);
            `CHK(refout_pin_out, (i > 0 && (i - 1) % n < hi), "wave shape")
          end
          `CHK(rises - r0, (dt > 0 ? 2 : 0), "edge count")
        end
    wcfg(1'b1, 2'h1, 3'h2);
    bus(1'b0, 2'h0, 8'h0, 4'hF); `CHK(rd, model_ctrl, "change while on")
    bus(1'b0, 2'h1, 8'h0, 4'hF); `CHK(rd[3], 1'b1, "change flag set")
    bus(1'b1, 2'h1, 8'h08, 4'h1);
    bus(1'b0, 2'h1, 8'h0, 4'hF); `CHK({rd[3], rd[0]}, 2'h1, "change flag cleared")
    wcfg(1'b0, 2'h2, 3'h3);
    repeat (4)
    begin
      @(negedge ref_clk_in);
      `CHK(refout_pin_out, 1'b0, "disabled output")
    end
    wcfg(1'b1, 2'h0, 3'h0);
    r0 = rises;
    repeat (8)
    begin
      @(posedge ref_clk_in);
      #2 `CHK(refout_pin_out, 1'b1, "base clock high")
      @(negedge ref_clk_in);
      #2 `CHK(refout_pin_out, 1'b0, "base clock low")
    end
    `CHK(rises - r0, 8, "base clock edges")
    wcfg(1'b1, 2'h2, 3'h4);
    repeat (11) @(negedge ref_clk_in);
    @(posedge ref_clk_in);
    sleep_in <= 1'b1;
    @(negedge ref_clk_in);
    lv = refout_pin_out;
    repeat (20)
    begin
      @(negedge ref_clk_in);
      `CHK(refout_pin_out, lv, "sleep hold")
    end
    bus(1'b0, 2'h1, 8'h0, 4'hF); `CHK(rd[2:0], {lv, 2'h2}, "frozen status")
    @(posedge ref_clk_in);
    sleep_in <= 1'b0;
    bus(1'b0, 2'h1, 8'h0, 4'hF); `CHK(rd[1:0], 2'h1, "running status")
    `CHK(faults, 0, "consumer copy")
    final_report();
  end
endmodule // tb_reference_clock_output_divider
`default_nettype wire
